//--- src/segment_sequence_player.sv
// Segment sequence player: APB registers, sequencer and output path
// How it works
// - Starting is refused when all segments together exceed 8 Mpts.
// - Each run/stop command toggles between stopped and started (playing, or waiting for a trigger in step mode).
// - Samples leave only while playing or waiting (not stopped) and the output enable is on.
// - Below 250MSa/s points are zero-order held or linearly interpolated.
// - Each segment amplitude is multiplied by one common scaling factor.
// - One common offset is added to every output sample.
// - Step mode uses manual or external triggers; continuous is internal.
// - Idle output is the segment end, middle or start value.
// - Playback begins at the programmed start segment.
// - Shorter set length: linear decimation, drop tail or drop head.
// - External trigger acts on the selected rising or falling edge.
// - Each segment repeats its loop count before moving on.
// - After a segment the next one comes from its next pointer.
`timescale 1ns/1ps
`include "ssp_cfg.svh"

module segment_sequence_player (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        extTrig,
  output ssp_pkg::ssp_dac_t dacOut
);

  localparam int NSEG = 8;
  localparam int NMEM = 64;

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [12:0]        ctrl_q, ctrl_d;
  logic [31:0]        rate_q, rate_d;
  logic [7:0]         scale_q, scale_d;
  logic [15:0]        offset_q, offset_d;
  logic [2:0]         startSeg_q, startSeg_d;
  logic [2:0]         segSel_q, segSel_d;
  ssp_pkg::ssp_seg_t  segs_q [NSEG];
  ssp_pkg::ssp_seg_t  segs_d [NSEG];
  logic [15:0]        mem_q [NMEM];
  logic [15:0]        mem_d [NMEM];
  logic [31:0]        prdata_q, prdata_d;
  logic               pready_q, pready_d;
  logic               pslverr_q, pslverr_d;
  logic               wrEn;
  logic [31:0]        readVal;
  logic               mapped;

  // ---------------------------------------------------------------
  // Player state
  // ---------------------------------------------------------------
  ssp_pkg::ssp_state_t state_q, state_d;
  logic [2:0]         seg_q, seg_d;
  logic [15:0]        j_q, j_d;
  logic [15:0]        loop_q, loop_d;
  logic [31:0]        acc_q, acc_d;
  logic               tooLong_q, tooLong_d;
  ssp_pkg::ssp_dac_t  dac_q, dac_d;
  logic [31:0]        segPts [NSEG];
  logic [34:0]        total;
  logic               runToggle, manualTrig, trig;
  logic               tick, lastPoint, lastLoop, segDone;
  logic [32:0]        accSum;
  logic [15:0]        lenEff, loopEff;
  ssp_pkg::ssp_seg_t  cur;
  logic [6:0]         ofs;
  logic               zeroFill, halfStep;

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a[11:8] == `SSP_MEM_PAGE) || (a <= `SSP_SEGB_OFS);
  endfunction : is_mapped

  function automatic logic [15:0] ssp_scale(input logic [15:0] s,
                                            input logic [7:0]  a,
                                            input logic [7:0]  k,
                                            input logic [15:0] o);
    logic signed [33:0] sx, ax, kx, p;
    sx = 34'($signed(s));
    ax = 34'({1'b0, a});
    kx = 34'({1'b0, k});
    // Both gains are 1.7 fixed point, so 0x80 leaves a sample untouched
    p  = ((sx * ax * kx) >>> 14) + 34'($signed(o));
    if (p > 34'sh0_0000_7fff) begin
      ssp_scale = 16'h7fff;
    end else if (p < -34'sh0_0000_8000) begin
      ssp_scale = 16'h8000;
    end else begin
      ssp_scale = p[15:0];
    end
  endfunction : ssp_scale

  // ---------------------------------------------------------------
  // APB slave and register file
  // ---------------------------------------------------------------
  assign wrEn       = psel & penable & pready_q & pwrite;
  assign mapped     = is_mapped(paddr);
  assign runToggle  = wrEn & (paddr == `SSP_CTRL_OFS) & pwdata[`SSP_C_RUN];
  assign manualTrig = wrEn & (paddr == `SSP_CTRL_OFS) & pwdata[`SSP_C_MAN];

  always_comb begin
    ctrl_d     = ctrl_q;
    rate_d     = rate_q;
    scale_d    = scale_q;
    offset_d   = offset_q;
    startSeg_d = startSeg_q;
    segSel_d   = segSel_q;
    segs_d     = segs_q;
    mem_d      = mem_q;
    // Answer one cycle after setup so read data leaves from a flop
    pready_d   = psel & ~penable & ~pready_q;
    pslverr_d  = psel & ~penable & ~pready_q & ~mapped;
    case (paddr)
      `SSP_CTRL_OFS:   readVal = {19'h0, ctrl_q};
      `SSP_STAT_OFS:   readVal = {16'h0, j_q[7:0], 1'b0, seg_q, 1'b0,
                                  tooLong_q, state_q};
      `SSP_RATE_OFS:   readVal = rate_q;
      `SSP_SCALE_OFS:  readVal = {24'h0, scale_q};
      `SSP_OFFS_OFS:   readVal = {16'h0, offset_q};
      `SSP_START_OFS:  readVal = {29'h0, startSeg_q};
      `SSP_SEGSEL_OFS: readVal = {29'h0, segSel_q};
      `SSP_SEGA_OFS:   readVal = {2'h0, segs_q[segSel_q].base, 1'b0,
                                  segs_q[segSel_q].storedLen,
                                  segs_q[segSel_q].setLen};
      `SSP_SEGB_OFS:   readVal = {segs_q[segSel_q].amp, 5'h0,
                                  segs_q[segSel_q].next,
                                  segs_q[segSel_q].loops};
      default:         readVal = mapped ? {16'h0, mem_q[paddr[7:2]]}
                                        : 32'h0;
    endcase
    prdata_d = pready_d ? readVal : 32'h0;
    if (wrEn) begin
      case (paddr)
        `SSP_CTRL_OFS:   ctrl_d     = pwdata[12:0] & `SSP_CTRL_MASK;
        `SSP_RATE_OFS:   rate_d     = pwdata;
        `SSP_SCALE_OFS:  scale_d    = pwdata[7:0];
        `SSP_OFFS_OFS:   offset_d   = pwdata[15:0];
        `SSP_START_OFS:  startSeg_d = pwdata[2:0];
        `SSP_SEGSEL_OFS: segSel_d   = pwdata[2:0];
        `SSP_SEGA_OFS: begin
          segs_d[segSel_q].setLen    = pwdata[15:0];
          segs_d[segSel_q].storedLen = pwdata[22:16];
          segs_d[segSel_q].base      = pwdata[29:24];
        end
        `SSP_SEGB_OFS: begin
          segs_d[segSel_q].loops = pwdata[15:0];
          segs_d[segSel_q].next  = pwdata[18:16];
          segs_d[segSel_q].amp   = pwdata[31:24];
        end
        default: begin
          if (paddr[11:8] == `SSP_MEM_PAGE) begin
            mem_d[paddr[7:2]] = pwdata[15:0];
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_q     <= `SSP_CTRL_RST;
      rate_q     <= `SSP_RATE_RST;
      scale_q    <= `SSP_SCALE_RST;
      offset_q   <= `SSP_OFFS_RST;
      startSeg_q <= 3'h0;
      segSel_q   <= 3'h0;
      prdata_q   <= 32'h0;
      pready_q   <= 1'b0;
      pslverr_q  <= 1'b0;
    end else begin
      ctrl_q     <= ctrl_d;
      rate_q     <= rate_d;
      scale_q    <= scale_d;
      offset_q   <= offset_d;
      startSeg_q <= startSeg_d;
      segSel_q   <= segSel_d;
      prdata_q   <= prdata_d;
      pready_q   <= pready_d;
      pslverr_q  <= pslverr_d;
    end
  end

  // Sample and segment storage keeps its contents through reset
  always_ff @(posedge ref_clk) begin
    segs_q <= segs_d;
    mem_q  <= mem_d;
  end

  // ---------------------------------------------------------------
  // Sequence length check
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NSEG; g++) begin : g_pts
      assign segPts[g] = 32'(segs_q[g].setLen) *
                         ((segs_q[g].loops == 16'h0) ? 32'h1
                                                    : 32'(segs_q[g].loops));
    end
  endgenerate

  always_comb begin
    total = 35'h0;
    for (int i = 0; i < NSEG; i++) begin
      total = total + 35'(segPts[i]);
    end
    tooLong_d = total > 35'(`SSP_MAX_POINTS);
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  ssp_trigger u_trig (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .extTrig    (extTrig),
    .manualTrig (manualTrig),
    .srcExt     (ctrl_q[`SSP_C_EXT]),
    .fallEdge   (ctrl_q[`SSP_C_FALL]),
    .trig       (trig)
  );

  assign cur       = segs_q[seg_q];
  assign lenEff    = (cur.setLen == 16'h0) ? 16'h1 : cur.setLen;
  assign loopEff   = (cur.loops == 16'h0) ? 16'h1 : cur.loops;
  assign accSum    = 33'(acc_q) + 33'(rate_q);
  assign tick      = accSum >= 33'(`SSP_CLK_KSPS);
  assign lastPoint = (j_q + 16'h1) >= lenEff;
  assign lastLoop  = (loop_q + 16'h1) >= loopEff;
  assign segDone   = (state_q == ssp_pkg::SSP_PLAY) & tick & lastPoint &
                     lastLoop;

  always_comb begin
    state_d = state_q;
    seg_d   = seg_q;
    j_d     = j_q;
    loop_d  = loop_q;
    acc_d   = acc_q;
    case (state_q)
      ssp_pkg::SSP_STOP: begin
        if (runToggle && !tooLong_q) begin
          seg_d   = startSeg_q;
          j_d     = 16'h0;
          loop_d  = 16'h0;
          acc_d   = 32'h0;
          state_d = ctrl_q[`SSP_C_STEP] ? ssp_pkg::SSP_WAIT
                                        : ssp_pkg::SSP_PLAY;
        end
      end
      ssp_pkg::SSP_WAIT: begin
        if (runToggle) begin
          state_d = ssp_pkg::SSP_STOP;
        end else if (trig) begin
          j_d     = 16'h0;
          loop_d  = 16'h0;
          acc_d   = 32'h0;
          state_d = ssp_pkg::SSP_PLAY;
        end
      end
      ssp_pkg::SSP_PLAY: begin
        // Triggers are not looked at here, so they drop while playing
        if (runToggle) begin
          state_d = ssp_pkg::SSP_STOP;
        end else if (tick) begin
          // At most one point per clock; faster rates are clipped
          acc_d = 32'(accSum - 33'(`SSP_CLK_KSPS));
          if (!lastPoint) begin
            j_d = j_q + 16'h1;
          end else begin
            j_d = 16'h0;
            if (!lastLoop) begin
              loop_d = loop_q + 16'h1;
            end else begin
              loop_d = 16'h0;
              seg_d  = cur.next;
              if (ctrl_q[`SSP_C_STEP]) begin
                state_d = ssp_pkg::SSP_WAIT;
              end
            end
          end
        end else begin
          acc_d = accSum[31:0];
        end
      end
      default: state_d = ssp_pkg::SSP_STOP;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q   <= ssp_pkg::SSP_STOP;
      seg_q     <= 3'h0;
      j_q       <= 16'h0;
      loop_q    <= 16'h0;
      acc_q     <= 32'h0;
      tooLong_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      seg_q     <= seg_d;
      j_q       <= j_d;
      loop_q    <= loop_d;
      acc_q     <= acc_d;
      tooLong_q <= tooLong_d;
    end
  end

  // ---------------------------------------------------------------
  // Output path
  // ---------------------------------------------------------------
  ssp_resample u_rs (
    .pointIdx  (j_q),
    .storedLen (cur.storedLen),
    .setLen    (cur.setLen),
    .shrink    (ctrl_q[`SSP_C_SHR_LO +: 2]),
    .grow      (ctrl_q[`SSP_C_GRW_LO +: 2]),
    .ofs       (ofs),
    .zero      (zeroFill),
    .half      (halfStep)
  );

  logic [5:0]         addrCur, addrNxt;
  logic signed [16:0] sCur, sNxt, diff;
  logic signed [25:0] interp;
  logic [19:0]        fracRaw;
  logic [8:0]         frac;
  logic [15:0]        pt, holdPt, lastOfs;

  always_comb begin
    addrCur = 6'(cur.base + 6'(ofs));
    addrNxt = ((7'(ofs) + 7'h1) < cur.storedLen) ? 6'(addrCur + 6'h1)
                                                 : addrCur;
    sCur    = zeroFill ? 17'sh0 : 17'($signed(mem_q[addrCur]));
    sNxt    = zeroFill ? 17'sh0 : 17'($signed(mem_q[addrNxt]));
    if (halfStep) begin
      sCur = (sCur + sNxt) >>> 1;
    end
    diff    = sNxt - sCur;
    fracRaw = 20'(acc_q) * 20'(`SSP_FRAC_MUL);
    frac    = (fracRaw[19:10] > 10'hff) ? 9'h0ff : {1'b0, fracRaw[17:10]};
    interp  = 26'(diff) * 26'($signed(frac));
    pt      = sCur[15:0];
    if ((rate_q < 32'(`SSP_LOWRATE_KSPS)) && ctrl_q[`SSP_C_LIN]) begin
      pt = 16'(sCur + 17'(interp >>> 8));
    end
    lastOfs = (cur.storedLen == 7'h0) ? 16'h0 : 16'(cur.storedLen - 7'h1);
    case (ctrl_q[`SSP_C_HOLD_LO +: 2])
      2'h0:    holdPt = mem_q[6'(cur.base + 6'(lastOfs))];
      2'h1:    holdPt = mem_q[6'(cur.base + 6'(cur.storedLen >> 1))];
      default: holdPt = mem_q[cur.base];
    endcase
    dac_d.valid = (state_q != ssp_pkg::SSP_STOP) & ctrl_q[`SSP_C_OUTEN];
    if (!dac_d.valid) begin
      dac_d.data = 16'h0;
    end else if (state_q == ssp_pkg::SSP_PLAY) begin
      dac_d.data = ssp_scale(pt, cur.amp, scale_q, offset_q);
    end else begin
      dac_d.data = ssp_scale(holdPt, cur.amp, scale_q, offset_q);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dac_q <= '0;
    end else begin
      dac_q <= dac_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign dacOut  = dac_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  output_gate_a: assert property (
    (state_q == ssp_pkg::SSP_STOP || !ctrl_q[`SSP_C_OUTEN]) |=>
      !dacOut.valid && dacOut.data == 16'h0)
    else $error("output active while stopped or disabled");
  run_toggle_a: assert property (
    (state_q == ssp_pkg::SSP_PLAY && runToggle) |=>
      state_q == ssp_pkg::SSP_STOP)
    else $error("run toggle did not stop playback");
  start_reject_a: assert property (
    (state_q == ssp_pkg::SSP_STOP && tooLong_q) |=>
      state_q == ssp_pkg::SSP_STOP)
    else $error("oversized sequence was started");
  start_seg_a: assert property (
    (state_q == ssp_pkg::SSP_STOP && runToggle && !tooLong_q) |=>
      state_q != ssp_pkg::SSP_STOP && seg_q == $past(startSeg_q) &&
      j_q == 16'h0)
    else $error("playback did not begin at start segment");
  step_trigger_a: assert property (
    (state_q == ssp_pkg::SSP_WAIT && trig && !runToggle) |=>
      state_q == ssp_pkg::SSP_PLAY ##1 dacOut.valid == ctrl_q[1])
    else $error("trigger did not start a step segment");
  step_one_seg_a: assert property (
    (segDone && ctrl_q[`SSP_C_STEP] && !runToggle) |=>
      state_q == ssp_pkg::SSP_WAIT)
    else $error("step mode played past one segment");
  cont_next_a: assert property (
    (segDone && !ctrl_q[`SSP_C_STEP] && !runToggle) |=>
      state_q == ssp_pkg::SSP_PLAY && seg_q == $past(cur.next))
    else $error("continuous mode did not follow next pointer");
  loop_count_a: assert property (
    (state_q == ssp_pkg::SSP_PLAY && tick && lastPoint && !lastLoop &&
     !runToggle) |=> loop_q == $past(loop_q) + 16'h1 && j_q == 16'h0)
    else $error("segment loop count not advanced");
  busy_ignore_a: assert property (
    (state_q == ssp_pkg::SSP_PLAY && trig && !lastPoint && !runToggle) |=>
      state_q == ssp_pkg::SSP_PLAY && seg_q == $past(seg_q) &&
      j_q == ($past(tick) ? $past(j_q) + 16'h1 : $past(j_q)))
    else $error("trigger disturbed a playing segment");

  start_cont_c: cover property (
    state_q == ssp_pkg::SSP_STOP ##1 state_q == ssp_pkg::SSP_PLAY);
  step_trig_c: cover property (
    state_q == ssp_pkg::SSP_WAIT && trig);
  seg_change_c: cover property (segDone && cur.next != seg_q);
  reject_c: cover property (
    state_q == ssp_pkg::SSP_STOP && runToggle && tooLong_q);

endmodule : segment_sequence_player

//--- src/ssp_cfg.svh
// Register map, field positions, reset values and timing of the player
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define SSP_CTRL_OFS     12'h000
`define SSP_STAT_OFS     12'h004
`define SSP_RATE_OFS     12'h008
`define SSP_SCALE_OFS    12'h00c
`define SSP_OFFS_OFS     12'h010
`define SSP_START_OFS    12'h014
`define SSP_SEGSEL_OFS   12'h018
`define SSP_SEGA_OFS     12'h01c
`define SSP_SEGB_OFS     12'h020
`define SSP_MEM_PAGE     4'h1

// ---------------------------------------------------------------
// Control field positions
// ---------------------------------------------------------------
`define SSP_C_RUN        0
`define SSP_C_OUTEN      1
`define SSP_C_STEP       2
`define SSP_C_EXT        3
`define SSP_C_FALL       4
`define SSP_C_MAN        5
`define SSP_C_HOLD_LO    6
`define SSP_C_LIN        8
`define SSP_C_SHR_LO     9
`define SSP_C_GRW_LO     11
`define SSP_CTRL_MASK    13'h1fde

// ---------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------
`define SSP_CTRL_RST     13'h0000
`define SSP_RATE_RST     32'h000003e8
`define SSP_SCALE_RST    8'h80
`define SSP_OFFS_RST     16'h0000
`define SSP_CLK_NS       100
`define SSP_CLK_KSPS     (1000000 / `SSP_CLK_NS)
`define SSP_LOWRATE_KSPS 250000
`define SSP_FRAC_MUL     27
`define SSP_MAX_POINTS   (8 * 1048576)

`endif

//--- src/ssp_pkg.sv
// Types shared by the segment sequence player
package ssp_pkg;

  typedef enum logic [1:0] {
    SSP_STOP = 2'b00,
    SSP_WAIT = 2'b01,
    SSP_PLAY = 2'b10
  } ssp_state_t;

  typedef struct packed {
    logic [5:0]  base;
    logic [6:0]  storedLen;
    logic [15:0] setLen;
    logic [15:0] loops;
    logic [2:0]  next;
    logic [7:0]  amp;
  } ssp_seg_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } ssp_dac_t;

endpackage : ssp_pkg

//--- src/ssp_trigger.sv
// Trigger source selection and edge detection
`timescale 1ns/1ps
`include "ssp_cfg.svh"

module ssp_trigger (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic extTrig,
  input  wire logic manualTrig,
  input  wire logic srcExt,
  input  wire logic fallEdge,
  output logic      trig
);

  logic extPrev_q;
  logic extPrev_d;
  logic trig_q;
  logic trig_d;

  always_comb begin
    extPrev_d = extTrig;
    if (srcExt) begin
      trig_d = fallEdge ? (extPrev_q & ~extTrig)
                        : (~extPrev_q & extTrig);
    end else begin
      trig_d = manualTrig;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      extPrev_q <= 1'b0;
      trig_q    <= 1'b0;
    end else begin
      extPrev_q <= extPrev_d;
      trig_q    <= trig_d;
    end
  end

  assign trig = trig_q;

endmodule : ssp_trigger

//--- src/ssp_resample.sv
// Maps an output point index of a segment to a stored sample offset
`timescale 1ns/1ps

module ssp_resample (
  input  wire logic [15:0] pointIdx,
  input  wire logic [6:0]  storedLen,
  input  wire logic [15:0] setLen,
  input  wire logic [1:0]  shrink,
  input  wire logic [1:0]  grow,
  output logic      [6:0]  ofs,
  output logic             zero,
  output logic             half
);

  logic [22:0] setEff;
  logic [22:0] stEff;
  logic [22:0] prod;
  logic [22:0] quot;
  logic [22:0] rem;

  always_comb begin
    setEff = (setLen == 16'h0000) ? 23'h000001 : 23'(setLen);
    stEff  = (storedLen == 7'h00) ? 23'h000001 : 23'(storedLen);
    prod   = 23'(pointIdx) * stEff;
    quot   = prod / setEff;
    rem    = prod % setEff;
    zero   = 1'b0;
    half   = 1'b0;
    ofs    = pointIdx[6:0];
    if (setEff < stEff) begin
      case (shrink)
        2'h0:    ofs = quot[6:0];
        2'h1:    ofs = pointIdx[6:0];
        2'h2:    ofs = 7'(23'(pointIdx) + stEff - setEff);
        default: ofs = quot[6:0];
      endcase
    end else if (setEff > stEff) begin
      case (grow)
        2'h0: begin
          ofs  = quot[6:0];
          half = (rem << 1) >= setEff;
        end
        2'h1: begin
          zero = 23'(pointIdx) >= stEff;
        end
        2'h2: begin
          if (23'(pointIdx) >= stEff) begin
            ofs = 7'(stEff - 23'h000001);
          end
        end
        2'h3:    ofs = 7'(23'(pointIdx) % stEff);
        default: ofs = quot[6:0];
      endcase
    end
  end

endmodule : ssp_resample

//--- tb/ssp_partner.sv
// Output converter and trigger source model of the player
`timescale 1ns/1ps
module ssp_partner (
  input  wire logic              ref_clk,
  input  wire ssp_pkg::ssp_dac_t dacOut,
  output logic                   extTrig
);
  logic [15:0] got[$];
  bit cap = 1'b0;
  initial extTrig = 1'b0;
  // Converter takes a sample on every valid cycle while cap is set
  always @(posedge ref_clk) begin
    if (cap && dacOut.valid === 1'b1)
      got.push_back(dacOut.data);
  end
  // Second edge lands while the step segment still plays
  task automatic fire(input bit fall);
    @(posedge ref_clk);
    extTrig <= fall;
    repeat (3) @(posedge ref_clk);
    repeat (2) begin
      @(posedge ref_clk);
      extTrig <= ~fall;
      @(posedge ref_clk);
      extTrig <= fall;
    end
  endtask : fire
endmodule : ssp_partner

//--- tb/test_segment_sequence_player.sv
// Self-checking bench of the segment sequence player
`timescale 1ns/1ps
`include "ssp_cfg.svh"
module test_segment_sequence_player;
  logic              ref_clk = 1'b0;
  logic              rst     = 1'b1;
  logic              psel    = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite  = 1'b0;
  logic [11:0]       paddr   = 12'h000;
  logic [31:0]       pwdata  = 32'h0;
  logic [31:0]       prdata, rd, cfg;
  logic              pready, pslverr, err, extTrig;
  logic [31:0]       seed = 32'h104f6588;
  ssp_pkg::ssp_dac_t dacOut;
  int                nMismatch = 0;
  int                comparisons = 0;
  int                mem[16];
  int                o, s;
  int                want[$];
  segment_sequence_player DUT (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .extTrig(extTrig), .dacOut(dacOut));
  ssp_partner far (.ref_clk(ref_clk), .dacOut(dacOut), .extTrig(extTrig));
  initial forever #50 ref_clk = ~ref_clk;
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  // Scale 0x40 halves each sample, offset 5
  function automatic int lvl(input int s);
    return ((s * 128 * 64) >>> 14) + 5;
  endfunction : lvl
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      nMismatch++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees ready
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic seg(input int i, b, sl, st, lp, nx);
    apb(1'b1, `SSP_SEGSEL_OFS, i);
    apb(1'b1, `SSP_SEGA_OFS, (b << 24) | (st << 16) | sl);
    apb(1'b1, `SSP_SEGB_OFS, 32'h80000000 | (nx << 16) | lp);
  endtask : seg
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, nMismatch);
    if (nMismatch == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (5000) @(posedge ref_clk);
    nMismatch++;
    give_verdict();
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    apb(1'b0, `SSP_RATE_OFS, 32'h0);
    chk("rate", `SSP_RATE_RST, rd);
    apb(1'b0, 12'h0fc, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      mem[i] = int'(seed[11:0]);
      apb(1'b1, 12'h100 + 12'(4 * i), {20'h0, seed[11:0]});
    end
    apb(1'b1, `SSP_RATE_OFS, 32'h2710);
    apb(1'b1, `SSP_SCALE_OFS, 32'h40);
    apb(1'b1, `SSP_OFFS_OFS, 32'h5);
    apb(1'b1, `SSP_START_OFS, 32'h1);
    for (int i = 0; i < 8; i++)
      seg(i, i == 1 ? 8 : 0, i == 1 ? 3 : 4, i == 1 ? 3 : 4, i ? 1 : 2, !i);
    seg(7, 0, 16'hffff, 4, 256, 0);
    apb(1'b1, `SSP_CTRL_OFS, 32'h3);
    apb(1'b0, `SSP_STAT_OFS, 32'h0);
    chk("refused", 32'h4, rd & 32'h7);
    seg(7, 0, 4, 4, 1, 0);
    apb(1'b1, `SSP_CTRL_OFS, 32'h1);
    apb(1'b0, `SSP_STAT_OFS, 32'h0);
    chk("started", 32'h2, rd & 32'h7);
    chk("valid", 32'h0, {31'h0, dacOut.valid});
    apb(1'b1, `SSP_CTRL_OFS, 32'h1);
    apb(1'b0, `SSP_STAT_OFS, 32'h0);
    chk("stopped", 32'h0, rd & 32'h3);
    want = {8, 9, 10, 0, 1, 2, 3, 0, 1, 2, 3, 8, 9, 10, 0, 1};
    far.cap = 1'b1;
    apb(1'b1, `SSP_CTRL_OFS, 32'h3);
    repeat (20) @(posedge ref_clk);
    far.cap = 1'b0;
    apb(1'b1, `SSP_CTRL_OFS, 32'h1);
    foreach (want[i])
      chk("sample", lvl(mem[want[i]]), far.got[i]);
    // Drop-head shrink, repeat grow, linear fill at half the clock rate
    seg(2, 0, 2, 4, 1, 3);
    seg(3, 0, 6, 4, 1, 2);
    apb(1'b1, `SSP_START_OFS, 32'h2);
    apb(1'b1, `SSP_RATE_OFS, 32'h1388);
    far.got.delete();
    far.cap = 1'b1;
    apb(1'b1, `SSP_CTRL_OFS, 32'h1d03);
    repeat (20) @(posedge ref_clk);
    far.cap = 1'b0;
    apb(1'b1, `SSP_CTRL_OFS, 32'h1);
    apb(1'b1, `SSP_START_OFS, 32'h1);
    for (int i = 0; i < 16; i++) begin
      o = (i < 4) ? 2 + i / 2 : (i / 2 - 2) % 4;
      s = mem[o];
      if (i % 2 && o < 3)
        s += ((mem[o + 1] - mem[o]) * ((5000 * `SSP_FRAC_MUL) >> 10)) >>> 8;
      chk("resampled", lvl(s), far.got[i]);
    end
    for (int k = 0; k < 3; k++) begin
      cfg = 32'h6 | (k ? 32'h8 : 0) | (k == 2 ? 32'h10 : 0) | (k << 6);
      apb(1'b1, `SSP_CTRL_OFS, cfg | 32'h1);
      if (k == 0)
        apb(1'b1, `SSP_CTRL_OFS, cfg | 32'h20);
      else
        far.fire(k == 2);
      repeat (10) @(posedge ref_clk);
      apb(1'b0, `SSP_STAT_OFS, 32'h0);
      chk("step", 32'h1, rd & 32'h73);
      chk("hold", 16'(lvl(mem[k ? 4 - 2 * k : 3])), dacOut.data);
      apb(1'b1, `SSP_CTRL_OFS, cfg | 32'h1);
    end
    give_verdict();
  end
endmodule : test_segment_sequence_player
